// [shared/video_timing_pkg.sv]
package video_timing_pkg;

  localparam int LINE_W = 10;
  localparam int PIX_W = 12;
  localparam int SYNC_STAGES = 3;

  // Line totals of the two frame formats
  localparam logic [9:0] LINES_60HZ = 10'h020D;
  localparam logic [9:0] LINES_50HZ = 10'h0271;
  localparam logic [9:0] LINE_FIRST = 10'h0001;

  // Byte positions inside a line
  localparam logic [11:0] PIX_FIRST = 12'h0000;
  localparam logic [11:0] EAV_CODE_POS = 12'h0003;
  localparam logic [11:0] CODE_LEN = 12'h0004;

  // Fixed byte values
  localparam logic [7:0] PRE_FF = 8'hFF;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] BLANK_CHROMA = 8'h80;
  localparam logic [7:0] BLANK_LUMA = 8'h10;

  // Nominal rates of the stream; one byte per rising link clock edge
  localparam int PIX_RATE_HZ = 13_500_000;
  localparam int BYTE_RATE_HZ = 27_000_000;
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int BYTES_PER_PAIR = 4;

  // Reset values
  localparam logic [7:0] BUS_RESET = 8'h80;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } run_state_t;

  typedef struct packed {
    logic [7:0] cb;
    logic [7:0] y0;
    logic [7:0] cr;
    logic [7:0] y1;
  } pixel_pair_t;

  typedef struct packed {
    logic [11:0] line_bytes;
    logic [11:0] pixel_start;
    logic [9:0] field2_start;
    logic [9:0] first_field_active_line;
    logic [9:0] second_field_active_line;
    logic [9:0] frame_preset;
    logic [3:0] field1_overlap;
    logic [3:0] field2_overlap;
  } geometry_t;

  typedef struct packed {
    logic en;
    logic [7:0] min;
    logic [7:0] max;
  } clip_cfg_t;

  // Timing code: 1, F, V, H and four protection bits
  function automatic logic [7:0] code_byte(input logic f, input logic v, input logic h);
    code_byte = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction : code_byte

endpackage : video_timing_pkg

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic [2:0] stage_q;
  logic level_q;

  // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], pin};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

  assign level = level_q;
  assign rise = (stage_q[1] == stage_q[2]) && stage_q[2] && !level_q;

endmodule : pin_sync

// [logic/byte_clip.sv]
`timescale 1ns/1ps
module byte_clip (
  input wire logic [7:0] data_in,
  input wire video_timing_pkg::clip_cfg_t cfg,
  output logic [7:0] data_out
);
  always_comb begin
    data_out = data_in;
    if (cfg.en) begin
      if (data_in < cfg.min) begin
        data_out = cfg.min;
      end else if (data_in > cfg.max) begin
        data_out = cfg.max;
      end
    end
  end

endmodule : byte_clip

// [logic/enhanced_video_output.sv]
// Notes on behaviour
// - Pixels go out in pairs, four bytes
// - Chroma of a pair belongs to first luma
// - Nominal 13.5 Mpix/s, 27 MB/s byte rate
// - Bytes change on rising video clock edge
// - Line: EAV, blanking, SAV, then active pixels
// - Codes preceded by FF, 00, 00 preamble
// - Code byte carries 4-bit protection field
// - Only the eight legal code bytes appear
// - Codes inserted with internal or external timing
// - Clipping limits picture bytes to min/max
// - Lines numbered 1..525 or 1..625
// - 525-line F/V flags follow standard table
// - 625-line F/V flags follow standard table
// - Progressive output via two identical fields
// - Line counter starts at one
// - Second field when line >= field-2 start
// - Active when line and pixel reach starts
// - Overlap settings are signed -8..+7
// - Positive overlap forward, negative backward
// - Overlap keeps old field flag, then switches
// - Field 1 overlap opens field 2 blanking
// - Field 2 overlap opens field 1 blanking
// - Blanking data 80,10,80,10 per pixel pair
`timescale 1ns/1ps
module enhanced_video_output (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic video_out_clock,
  input wire logic enable,
  input wire logic format_50hz,
  input wire logic ext_timing,
  input wire logic ext_frame_sync,
  input wire video_timing_pkg::geometry_t geometry,
  input wire video_timing_pkg::clip_cfg_t clip_cfg,
  input wire video_timing_pkg::pixel_pair_t pixel_in,
  output logic [7:0] video_out_bus,
  output logic pair_taken,
  output logic field_flag,
  output logic vblank_flag,
  output logic hblank_n,
  output logic running
);

  ////////////////////////////////////////////////////////////////////////////
  // Input crossings

  logic tick;
  logic sync_edge;

  // Link clock is sampled, so it must stay well below half of sys_clk
  pin_sync u_clk_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(video_out_clock),
    .level(),
    .rise(tick)
  );

  pin_sync u_frame_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(ext_frame_sync),
    .level(),
    .rise(sync_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  video_timing_pkg::run_state_t state_q;
  video_timing_pkg::run_state_t state_d;
  video_timing_pkg::pixel_pair_t pair_q;
  logic [11:0] pix_q;
  logic [9:0] line_q;
  logic sync_pend_q;
  logic [7:0] bus_q;
  logic taken_q;
  logic field_q;
  logic vblank_q;
  logic hblank_n_q;
  logic running_q;

  always_comb begin
    case (state_q)
      video_timing_pkg::ST_IDLE: state_d = enable ? video_timing_pkg::ST_RUN : state_q;
      video_timing_pkg::ST_RUN: state_d = enable ? state_q : video_timing_pkg::ST_IDLE;
      default: state_d = video_timing_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= video_timing_pkg::ST_IDLE;
      running_q <= 1'b0;
    end else if (tick) begin
      state_q <= state_d;
      running_q <= state_d == video_timing_pkg::ST_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry decode

  logic [9:0] frame_len;
  logic [9:0] pos1;
  logic [9:0] pos2;
  logic [9:0] neg1;
  logic [9:0] neg2;
  logic struct_f2;
  logic code_f;
  logic code_v;
  logic [11:0] sav_start;
  logic [11:0] pix_rel;
  logic line_end;
  logic frame_end;

  assign frame_len = format_50hz ? video_timing_pkg::LINES_50HZ
                                 : video_timing_pkg::LINES_60HZ;

  // Overlaps are 4-bit two's complement; split into forward and backward parts
  assign pos1 = geometry.field1_overlap[3] ? 10'h000 : {6'h00, geometry.field1_overlap};
  assign pos2 = geometry.field2_overlap[3] ? 10'h000 : {6'h00, geometry.field2_overlap};
  assign neg1 = geometry.field1_overlap[3] ? {6'h00, 4'(-geometry.field1_overlap)} : 10'h000;
  assign neg2 = geometry.field2_overlap[3] ? {6'h00, 4'(-geometry.field2_overlap)} : 10'h000;

  assign struct_f2 = line_q >= geometry.field2_start;

  // Field flag lags the structural field by the forward overlap
  always_comb begin
    if (struct_f2) begin
      code_f = line_q >= (geometry.field2_start + pos1);
    end else begin
      code_f = line_q < (video_timing_pkg::LINE_FIRST + pos2);
    end
  end

  // Backward overlap opens blanking in the tail of the previous field
  always_comb begin
    if (struct_f2) begin
      code_v = line_q < geometry.second_field_active_line;
    end else begin
      code_v = (line_q < geometry.first_field_active_line)
        || (line_q >= (geometry.field2_start - neg1));
    end
    if (line_q > (frame_len - neg2)) begin
      code_v = 1'b1;
    end
  end

  // Identical geometry for both fields gives progressive output
  assign sav_start = geometry.pixel_start - video_timing_pkg::CODE_LEN;
  assign pix_rel = pix_q - geometry.pixel_start;
  assign line_end = pix_q == (geometry.line_bytes - 12'h001);
  assign frame_end = line_q >= frame_len;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  // Pending sync survives until the next byte slot; the set wins the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_pend_q <= 1'b0;
    end else if (sync_edge && ext_timing) begin
      sync_pend_q <= 1'b1;
    end else if (tick) begin
      sync_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pix_q <= video_timing_pkg::PIX_FIRST;
      line_q <= video_timing_pkg::LINE_FIRST;
    end else if (tick) begin
      if (state_q != video_timing_pkg::ST_RUN) begin
        pix_q <= video_timing_pkg::PIX_FIRST;
        line_q <= video_timing_pkg::LINE_FIRST;
      end else if (sync_pend_q) begin
        pix_q <= video_timing_pkg::PIX_FIRST;
        line_q <= geometry.frame_preset;
      end else if (line_end) begin
        pix_q <= video_timing_pkg::PIX_FIRST;
        line_q <= frame_end ? video_timing_pkg::LINE_FIRST : line_q + 10'h001;
      end else begin
        pix_q <= pix_q + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte selection

  logic in_eav;
  logic in_sav;
  logic in_active;
  logic [1:0] code_idx;
  logic [7:0] raw_byte;
  logic [7:0] clipped;
  logic [7:0] byte_d;

  assign in_eav = pix_q <= video_timing_pkg::EAV_CODE_POS;
  assign in_sav = (pix_q >= sav_start) && (pix_q < geometry.pixel_start);
  assign in_active = !code_v && (pix_q >= geometry.pixel_start);
  assign code_idx = in_eav ? pix_q[1:0] : 2'(pix_q - sav_start);

  // Chroma of the pair is co-sited with the first luma sample
  always_comb begin
    case (pix_rel[1:0])
      2'h0: raw_byte = pixel_in.cb;
      2'h1: raw_byte = pair_q.y0;
      2'h2: raw_byte = pair_q.cr;
      default: raw_byte = pair_q.y1;
    endcase
  end

  byte_clip u_clip (
    .data_in(raw_byte),
    .cfg(clip_cfg),
    .data_out(clipped)
  );

  always_comb begin
    byte_d = pix_q[0] ? video_timing_pkg::BLANK_LUMA : video_timing_pkg::BLANK_CHROMA;
    if (in_eav || in_sav) begin
      case (code_idx)
        2'h0: byte_d = video_timing_pkg::PRE_FF;
        2'h1: byte_d = video_timing_pkg::PRE_ZERO;
        2'h2: byte_d = video_timing_pkg::PRE_ZERO;
        default: byte_d = video_timing_pkg::code_byte(code_f, code_v, in_eav);
      endcase
    end else if (in_active) begin
      byte_d = clipped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Updated only in the slot after a rising link edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_q <= video_timing_pkg::BUS_RESET;
    end else if (tick) begin
      bus_q <= (state_q == video_timing_pkg::ST_RUN) ? byte_d
                                                      : video_timing_pkg::BUS_RESET;
    end
  end

  // Whole pair is captured when its first byte leaves
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pair_q <= '0;
      taken_q <= 1'b0;
    end else begin
      taken_q <= 1'b0;
      if (tick && state_q == video_timing_pkg::ST_RUN && in_active && !in_sav
          && pix_rel[1:0] == video_timing_pkg::PHASE_RESET) begin
        pair_q <= pixel_in;
        taken_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      field_q <= 1'b0;
      vblank_q <= 1'b1;
      hblank_n_q <= 1'b1;
    end else if (tick) begin
      field_q <= code_f;
      vblank_q <= code_v;
      hblank_n_q <= !(state_q == video_timing_pkg::ST_RUN && pix_q < geometry.pixel_start);
    end
  end

  assign video_out_bus = bus_q;
  assign pair_taken = taken_q;
  assign field_flag = field_q;
  assign vblank_flag = vblank_q;
  assign hblank_n = hblank_n_q;
  assign running = running_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic run_tick;
  assign run_tick = tick && state_q == video_timing_pkg::ST_RUN;

  // Clipping applies to Y0 as well, so the order check compares clipped bytes
  logic [7:0] y0_clipped;
  byte_clip u_y0_ref (
    .data_in(pair_q.y0),
    .cfg(clip_cfg),
    .data_out(y0_clipped)
  );

  sequence s_first_byte;
    run_tick && in_active && !in_sav && pix_rel[1:0] == 2'h0;
  endsequence

  sequence s_pair_rest;
    ##1 taken_q ##[1:60] (run_tick && pix_rel[1:0] == 2'h1);
  endsequence

  a_preamble_ff: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && pix_q == 12'h000 |=> bus_q == 8'hFF)
    else $error("preamble does not open with FF");

  a_preamble_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && (pix_q == 12'h001 || pix_q == 12'h002) |=> bus_q == 8'h00)
    else $error("preamble zero byte wrong");

  a_eav_code: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && pix_q == 12'h003 |=> bus_q == {1'b1, $past(code_f), $past(code_v), 1'b1,
      $past(code_v) ^ 1'b1, $past(code_f) ^ 1'b1, $past(code_f) ^ $past(code_v),
      ~($past(code_f) ^ $past(code_v))})
    else $error("EAV protection bits wrong");

  a_code_legal: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && pix_q == 12'h003 |=> bus_q inside {8'h9D, 8'hB6, 8'hDA, 8'hF1})
    else $error("illegal EAV code byte");

  a_line_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    line_q >= 10'h001 && line_q <= frame_len)
    else $error("line counter out of range");

  a_blank_data: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && !in_eav && !in_sav && !in_active |=>
      bus_q == ($past(pix_q[0]) ? 8'h10 : 8'h80))
    else $error("blanking data wrong");

  a_clip_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && in_active && !in_sav && clip_cfg.en && clip_cfg.min <= clip_cfg.max |=>
      bus_q >= $past(clip_cfg.min) && bus_q <= $past(clip_cfg.max))
    else $error("active byte outside clip range");

  a_bus_on_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(bus_q) |-> $past(tick))
    else $error("bus changed without link edge");

  a_field_switch: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && struct_f2 && line_q >= geometry.field2_start + pos1 |=> field_q)
    else $error("field flag not switched after overlap");

  // Field flag may only move at a line start
  a_field_steady: assert property (@(posedge sys_clk) disable iff (!nrst)
    run_tick && pix_q != 12'h000 |=> $stable(field_q))
    else $error("field flag changed inside a line");

  a_pair_order: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_first_byte |-> s_pair_rest ##1 bus_q == $past(y0_clipped))
    else $error("second byte of pair is not Y0");

endmodule : enhanced_video_output

// [verification/video_rx_model.sv]
`timescale 1ns/1ps
module video_rx_model (
  output logic video_out_clock,
  input wire logic [7:0] video_out_bus
);
  logic [7:0] rx_q[$];

  // Video clock runs free at 8 sys_clk periods, each edge 12 ns after a sys_clk rising edge
  initial begin
    video_out_clock = 1'b0;
    #137;
    forever #200 video_out_clock = ~video_out_clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One byte per rising edge; bytes settle well before the next edge
  always @(posedge video_out_clock) begin
    rx_q.push_back(video_out_bus);
  end
endmodule : video_rx_model

// [verification/test_enhanced_video_output.sv]
`timescale 1ns/1ps
module test_enhanced_video_output;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic video_out_clock;
  logic enable = 1'b0;
  logic format_50hz = 1'b0;
  logic ext_timing = 1'b0;
  logic ext_frame_sync = 1'b0;
  video_timing_pkg::geometry_t geometry;
  video_timing_pkg::clip_cfg_t clip_cfg;
  video_timing_pkg::pixel_pair_t pixel_in;
  logic [7:0] video_out_bus;
  logic pair_taken;
  logic field_flag;
  logic vblank_flag;
  logic hblank_n;
  logic running;
  int fail_count = 0;
  int checked = 0;
  // Index is {F, V}
  localparam logic [7:0] sav_codes [4] = '{8'h80, 8'hAB, 8'hC7, 8'hEC};
  localparam logic [7:0] eav_codes [4] = '{8'h9D, 8'hB6, 8'hDA, 8'hF1};

  always #25 sys_clk = ~sys_clk;

  enhanced_video_output u_dut (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .video_out_clock(video_out_clock),
    .enable(enable),
    .format_50hz(format_50hz),
    .ext_timing(ext_timing),
    .ext_frame_sync(ext_frame_sync),
    .geometry(geometry),
    .clip_cfg(clip_cfg),
    .pixel_in(pixel_in),
    .video_out_bus(video_out_bus),
    .pair_taken(pair_taken),
    .field_flag(field_flag),
    .vblank_flag(vblank_flag),
    .hblank_n(hblank_n),
    .running(running)
  );

  video_rx_model u_rx (
    .video_out_clock(video_out_clock),
    .video_out_bus(video_out_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t byte %h expected %h", $time, got, exp);
    end
  endtask : compare_byte

  task automatic compare_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask : compare_flag

  function automatic logic [1:0] fv(input int l);
    if (format_50hz) begin
      if (l <= 22) return 2'h1;
      if (l <= 310) return 2'h0;
      if (l <= 312) return 2'h1;
      if (l <= 335) return 2'h3;
      return (l <= 623) ? 2'h2 : 2'h3;
    end
    if (l <= 3) return 2'h3;
    if (l <= 19) return 2'h1;
    if (l <= 263) return 2'h0;
    if (l <= 265) return 2'h1;
    return (l <= 282) ? 2'h3 : 2'h2;
  endfunction : fv

  function automatic logic [7:0] clamp(input logic [7:0] b);
    if (!clip_cfg.en) return b;
    if (b < clip_cfg.min) return clip_cfg.min;
    return (b > clip_cfg.max) ? clip_cfg.max : b;
  endfunction : clamp

  // Line of 16 bytes: EAV at 0, blanking 4-7, SAV at 8, one pair at 12
  function automatic logic [7:0] exp_byte(input int line, input int idx);
    logic [1:0] fl;
    logic [7:0] pix [4];
    fl = fv(line);
    pix = '{clamp(pixel_in.cb), clamp(pixel_in.y0), clamp(pixel_in.cr), clamp(pixel_in.y1)};
    case (idx)
      0, 8: return 8'hFF;
      1, 2, 9, 10: return 8'h00;
      3: return eav_codes[fl];
      11: return sav_codes[fl];
      default: return (idx < 12 || fl[0]) ? ((idx % 2) ? 8'h10 : 8'h80) : pix[idx - 12];
    endcase
  endfunction : exp_byte

  task automatic get_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (u_rx.rx_q.size() == 0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    b = 8'h00;
    if (u_rx.rx_q.size() == 0) begin
      fail_count++;
      $display("FAIL %0t no byte from link", $time);
    end else begin
      b = u_rx.rx_q.pop_front();
    end
  endtask : get_byte

  // Idle bytes before the first preamble are skipped
  task automatic check_lines(input int first, input int count);
    logic [7:0] b;
    logic [1:0] fl;
    int line;
    int k;
    line = first;
    k = 0;
    get_byte(b);
    while (b !== 8'hFF && k < 24) begin
      get_byte(b);
      k++;
    end
    for (int i = 0; i < count; i++) begin
      for (int j = 0; j < 16; j++) begin
        if (i + j > 0) get_byte(b);
        compare_byte(b, exp_byte(line, j));
        // Flags are looked at before the next slot moves them
        if (j == 0 || j == 12) begin
          fl = fv(line);
          compare_flag(field_flag, fl[1]);
          compare_flag(vblank_flag, fl[0]);
          compare_flag(hblank_n, j == 12);
        end
      end
      line = (line == (format_50hz ? 625 : 525)) ? 1 : line + 1;
    end
  endtask : check_lines

  task automatic set_format(input logic f50);
    @(negedge sys_clk);
    format_50hz = f50;
    geometry.field2_start = f50 ? 10'h0137 : 10'h0108;
    geometry.first_field_active_line = f50 ? 10'h0017 : 10'h0014;
    geometry.second_field_active_line = f50 ? 10'h0150 : 10'h011B;
    geometry.field2_overlap = f50 ? 4'hE : 4'h3;
  endtask : set_format

  // The reloading slot still shows an old byte, so two slots are dropped
  task automatic sync_at(input int preset);
    @(negedge sys_clk);
    geometry.frame_preset = preset[9:0];
    @(posedge video_out_clock);
    repeat (4) @(negedge sys_clk);
    ext_frame_sync = 1'b1;
    @(posedge video_out_clock);
    #1 u_rx.rx_q.delete();
    @(posedge video_out_clock);
    #1 u_rx.rx_q.delete();
    @(negedge sys_clk);
    ext_frame_sync = 1'b0;
  endtask : sync_at

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_internal;
    @(negedge sys_clk);
    u_rx.rx_q.delete();
    enable = 1'b1;
    ext_frame_sync = 1'b1;
    repeat (20) @(negedge sys_clk);
    compare_flag(running, 1'b1);
    check_lines(1, 4);
    @(negedge sys_clk);
    ext_frame_sync = 1'b0;
  endtask : test_internal

  task automatic test_frames;
    @(negedge sys_clk);
    ext_timing = 1'b1;
    sync_at(1);
    check_lines(1, 25);
    sync_at(260);
    check_lines(260, 30);
    sync_at(522);
    check_lines(522, 8);
    set_format(1'b1);
    sync_at(305);
    check_lines(305, 35);
    sync_at(620);
    check_lines(620, 30);
  endtask : test_frames

  task automatic test_clip;
    int n;
    set_format(1'b0);
    clip_cfg = '{1'b1, 8'h10, 8'hEB};
    pixel_in = '{8'h20, 8'hFF, 8'h00, 8'h80};
    sync_at(30);
    check_lines(30, 3);
    // Next active line captures a pair; the pulse stands one cycle
    n = 0;
    while (pair_taken !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    compare_flag(pair_taken, 1'b1);
    compare_flag(hblank_n, 1'b1);
    @(negedge sys_clk);
    compare_flag(pair_taken, 1'b0);
  endtask : test_clip

  task automatic test_disable;
    logic [7:0] b;
    @(negedge sys_clk);
    enable = 1'b0;
    repeat (40) @(negedge sys_clk);
    compare_flag(running, 1'b0);
    @(posedge video_out_clock);
    #1 u_rx.rx_q.delete();
    for (int i = 0; i < 6; i++) begin
      get_byte(b);
      compare_byte(b, 8'h80);
    end
  endtask : test_disable

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    geometry = '{12'h0010, 12'h000C, 10'h0108, 10'h0014, 10'h011B, 10'h0064, 4'h2, 4'h3};
    clip_cfg = '{1'b0, 8'h10, 8'hEB};
    pixel_in = '{8'h3C, 8'h5A, 8'hC3, 8'hA5};
    repeat (5) @(negedge sys_clk);
    compare_byte(video_out_bus, 8'h80);
    compare_flag(running, 1'b0);
    compare_flag(hblank_n, 1'b1);
    nrst = 1'b1;
    test_internal();
    test_frames();
    test_clip();
    test_disable();
    end_of_test();
  end

  // About 135 lines of 16 bytes at 400 ns each, plus margin
  initial begin
    #3_000_000;
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : test_enhanced_video_output
